// >>> hw/usr_pkg.sv
`default_nettype none
package usr_pkg;
    // register byte offsets
    localparam logic [3:0] USR_CTL1_OFS  = 4'h0;
    localparam logic [3:0] USR_CTL2_OFS  = 4'h4;
    localparam logic [3:0] USR_RXST_OFS  = 4'h8;
    localparam logic [3:0] USR_IRQ_OFS   = 4'hC;
    // first control register fields
    localparam int CTL1_RXENA_BIT  = 0;
    localparam int CTL1_TXENA_BIT  = 1;
    localparam int CTL1_SLEEP_BIT  = 2;
    localparam int CTL1_SRST_BIT   = 5;
    localparam int CTL1_RXIE_BIT   = 6;
    localparam logic [7:0] CTL1_RW_MASK = 8'h67;
    localparam logic [7:0] CTL1_RESET   = 8'h00;
    // second control register fields
    localparam int CTL2_TXIE_BIT   = 0;
    localparam int CTL2_RXIE_BIT   = 1;
    localparam int CTL2_TXMT_BIT   = 6;
    localparam int CTL2_TX_BUFFER_READY_BIT  = 7;
    localparam logic [1:0] CTL2_CFG_RESET = 2'h0;
    // receiver status fields
    localparam int RXST_WAKE_BIT   = 1;
    localparam int RXST_PE_BIT     = 2;
    localparam int RXST_OE_BIT     = 3;
    localparam int RXST_FE_BIT     = 4;
    localparam int RXST_BRK_BIT    = 5;
    localparam int RXST_RDY_BIT    = 6;
    localparam int RXST_ERR_BIT    = 7;
    localparam logic [7:0] RXST_RESET     = 8'h00;
    localparam logic [7:0] RXST_FAULT_MSK = 8'h3C;
    // interrupt status/mask layout, low bit is receive fault
    localparam int IRQ_RXFAULT_BIT = 0;
    localparam logic [7:0] IRQ_RESET = 8'h00;
    typedef enum logic [1:0] {
        USR_TX_IDLE = 2'b00,
        USR_TX_LOAD = 2'b01,
        USR_TX_SEND = 2'b11
    } usr_tx_state_t;
endpackage : usr_pkg
`default_nettype wire

// >>> hw/usr_soft_reset_ctrl.sv
`default_nettype none
module usr_soft_reset_ctrl
    import usr_pkg::*;
(
    // clock and reset
    input  wire logic        CLK_SYS,
    input  wire logic        RST_N,
    // wishbone slave
    input  wire logic        WB_CYC_I,
    input  wire logic        WB_STB_I,
    input  wire logic        WB_WE_I,
    input  wire logic [3:0]  WB_ADR_I,
    input  wire logic [3:0]  WB_SEL_I,
    input  wire logic [31:0] WB_DAT_I,
    output logic      [31:0] WB_DAT_O,
    output logic             WB_ACK_O,
    // serial port event inputs, same clock
    input  wire logic        TX_LOAD_EV,
    input  wire logic        TX_DONE_EV,
    input  wire logic        RX_WAKE_EV,
    input  wire logic        RX_PARITY_EV,
    input  wire logic        RX_OVERRUN_EV,
    input  wire logic        RX_FRAMING_EV,
    input  wire logic        RX_BREAK_EV,
    input  wire logic        RX_READY_EV,
    input  wire logic        RX_READ_EV,
    // control and state out
    output logic             SOFT_RESET_N,
    output logic             TX_ENABLE,
    output logic             RX_ENABLE,
    output logic [1:0]       TX_STATE,
    output logic             IRQ
);
    logic [7:0]    ctl1_q;
    logic [1:0]    ctl2_cfg_q;
    logic          tx_rdy_q;
    logic          tx_empty_q;
    logic [7:0]    rxst_q;
    logic [7:0]    rxst_d;
    logic [7:0]    irq_st_q;
    logic [7:0]    irq_msk_q;
    logic          ack_q;
    logic [31:0]   dat_q;
    logic          soft_reset_n;
    logic          rx_fault_irq_enable;
    logic          wr;
    logic          rd;
    logic          fault_rise;
    usr_tx_state_t tx_state_q;

    assign soft_reset_n        = ctl1_q[CTL1_SRST_BIT];
    assign rx_fault_irq_enable = ctl1_q[CTL1_RXIE_BIT];
    assign wr = WB_CYC_I && WB_STB_I && WB_WE_I && !ack_q && WB_SEL_I[0];
    assign rd = WB_CYC_I && WB_STB_I && !WB_WE_I && !ack_q;

    // bus answer one cycle after the request, ack drops the cycle after
    always_ff @(posedge CLK_SYS) begin
        if (!RST_N) begin
            ack_q <= 1'b0;
        end else begin
            ack_q <= WB_CYC_I && WB_STB_I && !ack_q;
        end
    end

    always_ff @(posedge CLK_SYS) begin
        if (!RST_N) begin
            dat_q <= 32'h0000_0000;
        end else if (rd) begin
            case (WB_ADR_I)
                USR_CTL1_OFS: dat_q <= {24'h00_0000, ctl1_q};
                USR_CTL2_OFS: dat_q <= {24'h00_0000, tx_rdy_q, tx_empty_q, 4'h0, ctl2_cfg_q};
                USR_RXST_OFS: dat_q <= {24'h00_0000, rxst_q};
                USR_IRQ_OFS:  dat_q <= {16'h0000, irq_msk_q, irq_st_q};
                default:      dat_q <= 32'h0000_0000;
            endcase
        end
    end

    // configuration: only system reset touches it, soft reset does not
    always_ff @(posedge CLK_SYS) begin
        if (!RST_N) begin
            ctl1_q     <= CTL1_RESET;
            ctl2_cfg_q <= CTL2_CFG_RESET;
        end else if (wr && WB_ADR_I == USR_CTL1_OFS) begin
            ctl1_q <= WB_DAT_I[7:0] & CTL1_RW_MASK;
        end else if (wr && WB_ADR_I == USR_CTL2_OFS) begin
            ctl2_cfg_q <= WB_DAT_I[1:0];
        end
    end

    // transmitter flags and state machine
    always_ff @(posedge CLK_SYS) begin
        if (!RST_N || !soft_reset_n) begin
            tx_rdy_q   <= 1'b1;
            tx_empty_q <= 1'b1;
            tx_state_q <= USR_TX_IDLE;
        end else begin
            case (tx_state_q)
                USR_TX_IDLE: begin
                    if (TX_LOAD_EV && ctl1_q[CTL1_TXENA_BIT]) begin
                        tx_state_q <= USR_TX_LOAD;
                        tx_rdy_q   <= 1'b0;
                        tx_empty_q <= 1'b0;
                    end
                end
                USR_TX_LOAD: begin
                    tx_state_q <= USR_TX_SEND;
                    tx_rdy_q   <= 1'b1;
                end
                USR_TX_SEND: begin
                    if (TX_LOAD_EV) begin
                        tx_rdy_q <= 1'b0;
                    end
                    if (TX_DONE_EV) begin
                        tx_state_q <= tx_rdy_q && !TX_LOAD_EV ? USR_TX_IDLE : USR_TX_LOAD;
                        tx_empty_q <= tx_rdy_q && !TX_LOAD_EV;
                    end
                end
                default: tx_state_q <= USR_TX_IDLE;
            endcase
        end
    end

    // receiver status: events set, reading the data clears; set wins
    always_comb begin
        rxst_d = rxst_q;
        if (RX_READ_EV) begin
            rxst_d = RXST_RESET;
        end
        if (ctl1_q[CTL1_RXENA_BIT]) begin
            if (RX_WAKE_EV)    rxst_d[RXST_WAKE_BIT] = 1'b1;
            if (RX_PARITY_EV)  rxst_d[RXST_PE_BIT]   = 1'b1;
            if (RX_OVERRUN_EV) rxst_d[RXST_OE_BIT]   = 1'b1;
            if (RX_FRAMING_EV) rxst_d[RXST_FE_BIT]   = 1'b1;
            if (RX_BREAK_EV)   rxst_d[RXST_BRK_BIT]  = 1'b1;
            if (RX_READY_EV)   rxst_d[RXST_RDY_BIT]  = 1'b1;
        end
        rxst_d[RXST_ERR_BIT] = |(rxst_d & RXST_FAULT_MSK);
    end

    always_ff @(posedge CLK_SYS) begin
        if (!RST_N || !soft_reset_n) begin
            rxst_q <= RXST_RESET;
        end else begin
            rxst_q <= rxst_d;
        end
    end

    // sticky interrupt status, write one to clear, a new event wins
    assign fault_rise = rxst_d[RXST_ERR_BIT] && !rxst_q[RXST_ERR_BIT] && soft_reset_n;

    always_ff @(posedge CLK_SYS) begin
        if (!RST_N) begin
            irq_st_q  <= IRQ_RESET;
            irq_msk_q <= IRQ_RESET;
        end else begin
            if (wr && WB_ADR_I == USR_IRQ_OFS) begin
                irq_st_q[IRQ_RXFAULT_BIT] <= irq_st_q[IRQ_RXFAULT_BIT] & ~WB_DAT_I[IRQ_RXFAULT_BIT];
            end
            if (fault_rise && rx_fault_irq_enable) begin
                irq_st_q[IRQ_RXFAULT_BIT] <= 1'b1;
            end
            if (WB_CYC_I && WB_STB_I && WB_WE_I && !ack_q && WB_SEL_I[1] && WB_ADR_I == USR_IRQ_OFS) begin
                irq_msk_q <= WB_DAT_I[15:8] & 8'h01;
            end
        end
    end

    // outputs registered
    always_ff @(posedge CLK_SYS) begin
        if (!RST_N) begin
            SOFT_RESET_N <= 1'b0;
            TX_ENABLE    <= 1'b0;
            RX_ENABLE    <= 1'b0;
            TX_STATE     <= USR_TX_IDLE;
            IRQ          <= 1'b0;
        end else begin
            SOFT_RESET_N <= soft_reset_n;
            TX_ENABLE    <= ctl1_q[CTL1_TXENA_BIT];
            RX_ENABLE    <= ctl1_q[CTL1_RXENA_BIT];
            TX_STATE     <= tx_state_q;
            IRQ          <= |(irq_st_q & irq_msk_q);
        end
    end

    assign WB_ACK_O = ack_q;
    assign WB_DAT_O = dat_q;
endmodule : usr_soft_reset_ctrl
`default_nettype wire

// >>> verification/usr_soft_reset_ctrl_properties.sv
`default_nettype none
module usr_src_chk
    import usr_pkg::*;
(
    // clock and reset
    input wire logic        CLK_SYS,
    input wire logic        RST_N,
    // bus
    input wire logic        WB_CYC_I,
    input wire logic        WB_STB_I,
    input wire logic        WB_WE_I,
    input wire logic [3:0]  WB_ADR_I,
    input wire logic [3:0]  WB_SEL_I,
    input wire logic [31:0] WB_DAT_I,
    input wire logic [31:0] WB_DAT_O,
    input wire logic        WB_ACK_O,
    // state
    input wire logic        SOFT_RESET_N,
    input wire logic        RX_ENABLE,
    input wire logic [1:0]  TX_STATE,
    input wire logic        IRQ
);
    default clocking @(posedge CLK_SYS); endclocking
    default disable iff (!RST_N);
    logic wr1, wr_run, rd;
    assign wr1 = WB_CYC_I && WB_STB_I && WB_WE_I && WB_ADR_I == USR_CTL1_OFS && WB_SEL_I[0];
    assign wr_run = wr1 && WB_DAT_I[5];
    // read answers are judged only once the held reset has been visible a full cycle
    assign rd = WB_ACK_O && !WB_WE_I && !SOFT_RESET_N;
    property p_enter; wr1 && !WB_DAT_I[5] && !WB_ACK_O |-> ##[1:3] !SOFT_RESET_N; endproperty
    a_enter: assert property (p_enter) else $error("soft reset not entered");
    property p_exit; $rose(SOFT_RESET_N) |-> $past(wr_run) || $past(wr_run, 2); endproperty
    a_exit: assert property (p_exit) else $error("soft reset left without write");
    property p_txidle; !SOFT_RESET_N && !$past(SOFT_RESET_N) |-> TX_STATE == USR_TX_IDLE; endproperty
    a_txidle: assert property (p_txidle) else $error("tx state moved in reset");
    property p_ctl2; rd && WB_ADR_I == USR_CTL2_OFS && !$past(SOFT_RESET_N) |-> WB_DAT_O[7:6] == 2'h3; endproperty
    a_ctl2: assert property (p_ctl2) else $error("tx flags not set in reset");
    property p_rxlo; rd && WB_ADR_I == USR_RXST_OFS && !$past(SOFT_RESET_N) |-> WB_DAT_O[3:1] == 3'h0; endproperty
    a_rxlo: assert property (p_rxlo) else $error("rx low flags set in reset");
    property p_rxhi; rd && WB_ADR_I == USR_RXST_OFS && !$past(SOFT_RESET_N) |-> WB_DAT_O[7:4] == 4'h0; endproperty
    a_rxhi: assert property (p_rxhi) else $error("rx high flags set in reset");
    property p_cfg; wr1 && !WB_ACK_O |-> ##3 RX_ENABLE == $past(WB_DAT_I[0], 3); endproperty
    a_cfg: assert property (p_cfg) else $error("rx enable lost");
    property p_irq; $fell(IRQ) |-> $past(WB_ACK_O) || $past(WB_ACK_O, 2); endproperty
    a_irq: assert property (p_irq) else $error("irq dropped without write");
endmodule : usr_src_chk
bind usr_soft_reset_ctrl usr_src_chk i_usr_src_chk (.*);
`default_nettype wire

// >>> verification/usr_host_model.sv
`default_nettype none
module usr_host_model (
    // clock
    input  wire logic        CLK_SYS,
    // wishbone master
    output var  logic        WB_CYC_I,
    output var  logic        WB_STB_I,
    output var  logic        WB_WE_I,
    output var  logic [3:0]  WB_ADR_I,
    output var  logic [3:0]  WB_SEL_I,
    output var  logic [31:0] WB_DAT_I,
    input  wire logic [31:0] WB_DAT_O,
    input  wire logic        WB_ACK_O
);
    timeunit 1ns;
    timeprecision 1ns;
    initial {WB_CYC_I, WB_STB_I, WB_WE_I, WB_ADR_I, WB_SEL_I, WB_DAT_I} = '0;
    // no assumed latency: only the bench timeout ends a missing ack
    task automatic xfer(input logic we, input logic [3:0] a, input logic [31:0] d, output logic [31:0] q);
        @(posedge CLK_SYS);
        {WB_CYC_I, WB_STB_I, WB_WE_I, WB_ADR_I, WB_SEL_I, WB_DAT_I} <= {2'h3, we, a, 4'h3, d};
        do @(posedge CLK_SYS); while (WB_ACK_O !== 1'b1);
        q = WB_DAT_O;
        {WB_CYC_I, WB_STB_I, WB_WE_I} <= 3'h0;
    endtask : xfer
endmodule : usr_host_model
`default_nettype wire

// >>> verification/usr_soft_reset_ctrl_bench.sv
`default_nettype none
`define CHK(a, e) begin checked++; if ((a) !== (e)) begin error_cnt++; \
    $display("unexpected at %0t: got %h expected %h", $time, a, e); end end
module usr_soft_reset_ctrl_bench
    import usr_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    logic CLK_SYS = 1'b0, RST_N = 1'b0, TX_LOAD_EV = 1'b0, TX_DONE_EV = 1'b0, RX_READ_EV = 1'b0;
    logic RX_WAKE_EV = 1'b0, RX_PARITY_EV = 1'b0, RX_OVERRUN_EV = 1'b0;
    logic RX_FRAMING_EV = 1'b0, RX_BREAK_EV = 1'b0, RX_READY_EV = 1'b0;
    wire logic WB_CYC_I, WB_STB_I, WB_WE_I, WB_ACK_O, SOFT_RESET_N, TX_ENABLE, RX_ENABLE, IRQ;
    wire logic [3:0]  WB_ADR_I, WB_SEL_I;
    wire logic [31:0] WB_DAT_I, WB_DAT_O;
    wire logic [1:0]  TX_STATE;
    logic [31:0] rd;
    int error_cnt = 0, checked = 0, cyc_cnt = 0;
    // receive events to pulse, receiver status expected after them (flags are sticky)
    logic [13:0] rows [6] = '{14'h0102, 14'h0286, 14'h048E, 14'h089E, 14'h10BE, 14'h20FE};
    usr_soft_reset_ctrl i_usr_soft_reset_ctrl (.*);
    usr_host_model i_usr_host_model (.*);
    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        i_usr_host_model.xfer(1'b1, a, d, rd);
    endtask : wr
    task automatic rdc(input logic [3:0] a, input logic [31:0] e);
        i_usr_host_model.xfer(1'b0, a, 32'h0, rd);
        `CHK(rd, e)
    endtask : rdc
    // event bits, high to low: tx done, rx read, tx load, then ready down to wake
    task automatic pulse(input logic [8:0] ev);
        repeat (2) begin
            @(posedge CLK_SYS);
            {TX_DONE_EV, RX_READ_EV, TX_LOAD_EV, RX_READY_EV, RX_BREAK_EV,
             RX_FRAMING_EV, RX_OVERRUN_EV, RX_PARITY_EV, RX_WAKE_EV} <= ev;
            ev = 9'h000;
        end
    endtask : pulse
    task automatic print_verdict;
        $display("checked %0d, error_cnt %0d", checked, error_cnt);
        if (error_cnt == 0 && checked > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : print_verdict
    initial begin
        forever #20 CLK_SYS = ~CLK_SYS;
    end
    always @(posedge CLK_SYS) begin
        cyc_cnt <= cyc_cnt + 1;
        if (cyc_cnt == 2000) begin
            error_cnt++;
            print_verdict();
        end
    end
    initial begin
        repeat (3) @(posedge CLK_SYS);
        RST_N <= 1'b1;
        `CHK(SOFT_RESET_N, 1'b0)
        rdc(USR_CTL2_OFS, 32'hC0);
        rdc(USR_RXST_OFS, 32'h0);
        wr(USR_CTL1_OFS, 32'h01);
        pulse(9'h03F);
        rdc(USR_RXST_OFS, 32'h0);
        wr(USR_IRQ_OFS, 32'h100);
        wr(USR_CTL1_OFS, 32'h63);
        foreach (rows[i]) begin
            pulse({3'h0, rows[i][13:8]});
            rdc(USR_RXST_OFS, {24'h0, rows[i][7:0]});
        end
        // a data read and a new event in one cycle: the event survives
        pulse(9'h0A0);
        rdc(USR_RXST_OFS, 32'h40);
        `CHK(IRQ, 1'b1)
        `CHK(TX_ENABLE, 1'b1)
        wr(USR_CTL2_OFS, 32'h03);
        pulse(9'h040);
        rdc(USR_CTL2_OFS, 32'h83);
        `CHK(TX_STATE, 2'h3)
        pulse(9'h010);
        // break is latched, so software asserts and holds the soft reset to clear it
        wr(USR_CTL1_OFS, 32'h43);
        rdc(USR_CTL2_OFS, 32'hC3);
        rdc(USR_RXST_OFS, 32'h0);
        rdc(USR_CTL1_OFS, 32'h43);
        `CHK(TX_STATE, 2'h0)
        `CHK(SOFT_RESET_N, 1'b0)
        `CHK(RX_ENABLE, 1'b1)
        wr(USR_IRQ_OFS, 32'h101);
        @(posedge CLK_SYS);
        `CHK(IRQ, 1'b0)
        // load and overrun events while held must leave the flags alone
        pulse(9'h044);
        rdc(USR_CTL2_OFS, 32'hC3);
        rdc(USR_RXST_OFS, 32'h0);
        wr(USR_CTL1_OFS, 32'h63);
        pulse(9'h002);
        rdc(USR_RXST_OFS, 32'h84);
        `CHK(SOFT_RESET_N, 1'b1)
        pulse(9'h040);
        pulse(9'h100);
        rdc(USR_CTL2_OFS, 32'hC3);
        `CHK(TX_STATE, 2'h0)
        rdc(4'h2, 32'h0);
        // system reset in mid-run clears configuration and holds the soft reset again
        RST_N <= 1'b0;
        repeat (3) @(posedge CLK_SYS);
        RST_N <= 1'b1;
        rdc(USR_CTL1_OFS, 32'h0);
        rdc(USR_CTL2_OFS, 32'hC0);
        `CHK(SOFT_RESET_N, 1'b0)
        `CHK(IRQ, 1'b0)
        print_verdict();
    end
endmodule : usr_soft_reset_ctrl_bench
`default_nettype wire
